/* rtl/wake_timer_controller.sv */
// wake-up timer controller with wake-up counting, interrupts and an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "wake_timer_consts.svh"
// Summary of operation
// - wake timer is a 16-bit down counter clocked through a 3-bit prescaler
// - clock select bit 4 picks RC oscillator at 1, crystal at 0; separate enables
// - bit 3 keeps retention memory powered in sleep; 0 removes it
// - timeout wakes from sleep only while arm bit 0 is set
// - prescale codes give dividers 1,4,8,16,128,1034,8192,65536 of the slow clock
// - load value is high byte over low byte; interval is value times tick
// - counting restarts from the value once both value bytes are written
// - config and value bytes are write only; reserved bits written zero
// - every hardware wake that does not exceed the threshold increments the 16-bit wake-up count
// - count exceeding the threshold is cleared to zero
// - exceeding raises masked count interrupt and moves to idle off state
// - count not above threshold sends the device back to sleep
// - each wake raises the masked timeout interrupt regardless of the threshold
module wake_timer_controller #(
	parameter int ADDR_W = 14
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rc_osc_clk,
	input wire logic crystal_osc_clk,
	output logic rc_osc_enable,
	output logic crystal_osc_enable,
	output logic retention_power_enable,
	output logic sleep_state,
	output logic idle_off_state,
	output logic host_interrupt_pin
);
	import wake_timer_pkg::*;

	logic aw_held;
	logic w_held;
	logic [11:0] wr_idx;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic do_write;
	logic [31:0] held_wdata;
	logic [3:0] held_wstrb;
	logic [7:0] config_high;
	logic [7:0] config_low;
	logic [7:0] config_high_hold;
	logic [7:0] value_high_hold;
	logic [15:0] timer_load_value;
	logic cfg_pair_open;
	logic val_pair_open;
	logic cfg_commit;
	logic val_commit;
	logic [15:0] wakeup_count;
	logic [15:0] wakeup_threshold;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [1:0] irq_set;
	logic [1:0] irq_clear;
	logic [16:0] count_plus_one;
	logic count_exceeds;
	logic tick;
	logic timeout;
	logic cmd_sleep;
	logic cmd_off;
	power_state_t state;
	power_state_t next_state;

	function automatic logic is_mapped(input logic [11:0] idx);
		is_mapped = (idx == `IDX_IRQ_ENABLE) || (idx == `IDX_COUNT_A) || (idx == `IDX_COUNT_B)
			|| (idx == `IDX_THRESH_A) || (idx == `IDX_THRESH_B)
			|| (idx == `IDX_CONFIG_HIGH) || (idx == `IDX_CONFIG_LOW)
			|| (idx == `IDX_VALUE_HIGH) || (idx == `IDX_VALUE_LOW)
			|| (idx == `IDX_IRQ_STATUS) || (idx == `IDX_IRQ_CLEAR)
			|| (idx == `IDX_COMMAND) || (idx == `IDX_STATE);
	endfunction

	function automatic logic wr_to(input logic [11:0] idx, input logic [11:0] target);
		wr_to = (idx == target);
	endfunction

	// write address and data are taken in either order, then answered
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign do_write = aw_held && w_held;
	assign wr_byte = held_wdata[7:0];
	assign wr_lane = held_wstrb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_idx <= 12'h000;
			held_wdata <= 32'h00000000;
			held_wstrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr_idx <= awaddr[13:2];
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				held_wdata <= wdata;
				held_wstrb <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// paired byte writes; any other write between the two breaks the pair
	assign cfg_commit = do_write && wr_lane && cfg_pair_open
		&& wr_to(wr_idx, `IDX_CONFIG_LOW);
	assign val_commit = do_write && wr_lane && val_pair_open
		&& wr_to(wr_idx, `IDX_VALUE_LOW);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_pair_open <= 1'b0;
			val_pair_open <= 1'b0;
			config_high_hold <= `RESET_BYTE;
			value_high_hold <= `RESET_BYTE;
		end else if (do_write) begin
			cfg_pair_open <= wr_lane && wr_to(wr_idx, `IDX_CONFIG_HIGH);
			val_pair_open <= wr_lane && wr_to(wr_idx, `IDX_VALUE_HIGH);
			if (wr_lane && wr_to(wr_idx, `IDX_CONFIG_HIGH)) begin
				config_high_hold <= wr_byte;
			end
			if (wr_lane && wr_to(wr_idx, `IDX_VALUE_HIGH)) begin
				value_high_hold <= wr_byte;
			end
		end
	end

	// reserved config bits are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_high <= `RESET_BYTE;
			config_low <= `RESET_BYTE;
		end else if (cfg_commit) begin
			config_high <= config_high_hold & `CFG_HIGH_USED_MASK;
			config_low <= wr_byte & `CFG_LOW_USED_MASK;
		end
	end

	// high byte over low byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_load_value <= `RESET_WORD;
		end else if (val_commit) begin
			timer_load_value <= {value_high_hold, wr_byte};
		end
	end

	assign rc_osc_enable = config_low[`CFG_INTERNAL_RC_OSCILLATOR_EN_BIT];
	assign crystal_osc_enable = config_low[`CFG_EXTERNAL_CRYSTAL_OSCILLATOR_EN_BIT];

	slow_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.rc_osc_clk(rc_osc_clk),
		.crystal_osc_clk(crystal_osc_clk),
		.rc_osc_enable(config_low[`CFG_INTERNAL_RC_OSCILLATOR_EN_BIT]),
		.crystal_osc_enable(config_low[`CFG_EXTERNAL_CRYSTAL_OSCILLATOR_EN_BIT]),
		.slow_clock_select(config_low[`CFG_CLKSEL_BIT]),
		.tick_prescale_select(config_high[2:0]),
		.restart(val_commit),
		.tick(tick)
	);

	wake_down_counter #(
		.WIDTH(16)
	) u_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(val_commit),
		.load_value({value_high_hold, wr_byte}),
		.tick(tick),
		.timeout(timeout)
	);

	assign cmd_sleep = do_write && wr_lane && wr_to(wr_idx, `IDX_COMMAND)
		&& wr_byte[`CMD_SLEEP_BIT];
	assign cmd_off = do_write && wr_lane && wr_to(wr_idx, `IDX_COMMAND)
		&& wr_byte[`CMD_OFF_BIT];
	assign count_plus_one = {1'b0, wakeup_count} + 17'd1;
	assign count_exceeds = count_plus_one > {1'b0, wakeup_threshold};

	// power state sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF: begin
				if (cmd_sleep) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (cmd_off) begin
					next_state = ST_OFF;
				end else if (timeout && config_low[`CFG_ARM_BIT]) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				next_state = count_exceeds ? ST_OFF : ST_SLEEP;
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	assign sleep_state = (state == ST_SLEEP);
	assign idle_off_state = (state == ST_OFF);
	// memory stays powered except in sleep with retention off
	assign retention_power_enable = (state != ST_SLEEP) || config_low[`CFG_RETAIN_BIT];

	// wake-up count; a hardware wake wins over a host write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wakeup_count <= `RESET_WORD;
		end else if (state == ST_WAKE) begin
			wakeup_count <= count_exceeds ? `RESET_WORD : count_plus_one[15:0];
		end else if (do_write && wr_lane && wr_to(wr_idx, `IDX_COUNT_A)) begin
			wakeup_count[7:0] <= wr_byte;
		end else if (do_write && wr_lane && wr_to(wr_idx, `IDX_COUNT_B)) begin
			wakeup_count[15:8] <= wr_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wakeup_threshold <= `RESET_WORD;
			irq_enable <= 2'h0;
		end else if (do_write && wr_lane) begin
			if (wr_to(wr_idx, `IDX_THRESH_A)) begin
				wakeup_threshold[7:0] <= wr_byte;
			end
			if (wr_to(wr_idx, `IDX_THRESH_B)) begin
				wakeup_threshold[15:8] <= wr_byte;
			end
			if (wr_to(wr_idx, `IDX_IRQ_ENABLE)) begin
				irq_enable <= wr_byte[1:0];
			end
		end
	end

	// sticky events; a new event wins over a clear in the same cycle
	assign irq_set = {state == ST_WAKE, (state == ST_WAKE) && count_exceeds};
	assign irq_clear = (do_write && wr_lane && wr_to(wr_idx, `IDX_IRQ_CLEAR))
		? wr_byte[1:0] : 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= 2'h0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_set;
		end
	end

	assign host_interrupt_pin = |(irq_status & irq_enable);

	// reads; write-only bytes read as zero
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= is_mapped(araddr[13:2]) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (araddr[13:2])
				`IDX_IRQ_ENABLE: rdata <= {30'h0, irq_enable};
				`IDX_COUNT_A: rdata <= {24'h0, wakeup_count[7:0]};
				`IDX_COUNT_B: rdata <= {24'h0, wakeup_count[15:8]};
				`IDX_THRESH_A: rdata <= {24'h0, wakeup_threshold[7:0]};
				`IDX_THRESH_B: rdata <= {24'h0, wakeup_threshold[15:8]};
				`IDX_IRQ_STATUS: rdata <= {30'h0, irq_status};
				`IDX_STATE: rdata <= {30'h0, state};
				default: rdata <= 32'h00000000;
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_unarmed_stays;
		(state == ST_SLEEP) && timeout && !config_low[`CFG_ARM_BIT] && !cmd_off
			|=> state == ST_SLEEP;
	endproperty
	a_unarmed_stays: assert property (p_unarmed_stays) else $error("woke while unarmed");

	property p_armed_wakes;
		(state == ST_SLEEP) && timeout && config_low[`CFG_ARM_BIT] && !cmd_off
			|=> state == ST_WAKE;
	endproperty
	a_armed_wakes: assert property (p_armed_wakes) else $error("armed timeout ignored");

	property p_count_increments;
		(state == ST_WAKE) && !count_exceeds |=> wakeup_count == $past(wakeup_count) + 16'h0001;
	endproperty
	a_count_increments: assert property (p_count_increments) else $error("count not stepped");

	property p_count_cleared;
		(state == ST_WAKE) && count_exceeds |=> wakeup_count == 16'h0000;
	endproperty
	a_count_cleared: assert property (p_count_cleared) else $error("count not cleared");

	property p_exceed_goes_off;
		(state == ST_WAKE) && count_exceeds
			|=> idle_off_state && irq_status[`IRQ_COUNT_BIT];
	endproperty
	a_exceed_goes_off: assert property (p_exceed_goes_off) else $error("no off after exceed");

	property p_back_to_sleep;
		(state == ST_WAKE) && !count_exceeds |=> sleep_state && !irq_status[`IRQ_COUNT_BIT]
			|| $past(irq_status[`IRQ_COUNT_BIT]);
	endproperty
	a_back_to_sleep: assert property (p_back_to_sleep) else $error("no return to sleep");

	property p_timeout_irq;
		(state == ST_WAKE) && irq_enable[`IRQ_TIMEOUT_BIT] && !$past(cmd_off)
			|=> host_interrupt_pin && irq_status[`IRQ_TIMEOUT_BIT];
	endproperty
	a_timeout_irq: assert property (p_timeout_irq) else $error("timeout irq missing");

	property p_retention_off;
		sleep_state && !config_low[`CFG_RETAIN_BIT] |-> !retention_power_enable;
	endproperty
	a_retention_off: assert property (p_retention_off) else $error("retention power left on");

	property p_pair_commit;
		do_write && wr_lane && wr_to(wr_idx, `IDX_CONFIG_LOW) && !cfg_pair_open
			|=> config_low == $past(config_low);
	endproperty
	a_pair_commit: assert property (p_pair_commit) else $error("unpaired config applied");
endmodule

/* rtl/wake_timer_consts.svh */
// register indices, field positions, reset values and divider figures of the wake timer
`ifndef WAKE_TIMER_CONSTS_SVH
`define WAKE_TIMER_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_IRQ_ENABLE 12'h100
`define IDX_COUNT_A 12'h102
`define IDX_COUNT_B 12'h103
`define IDX_THRESH_A 12'h104
`define IDX_THRESH_B 12'h105
`define IDX_CONFIG_HIGH 12'h30C
`define IDX_CONFIG_LOW 12'h30D
`define IDX_VALUE_HIGH 12'h30E
`define IDX_VALUE_LOW 12'h30F
`define IDX_IRQ_STATUS 12'h320
`define IDX_IRQ_CLEAR 12'h321
`define IDX_COMMAND 12'h322
`define IDX_STATE 12'h323

// config low byte fields and used-bit masks of both config bytes
`define CFG_ARM_BIT 0
`define CFG_RETAIN_BIT 3
`define CFG_CLKSEL_BIT 4
`define CFG_EXTERNAL_CRYSTAL_OSCILLATOR_EN_BIT 5
`define CFG_INTERNAL_RC_OSCILLATOR_EN_BIT 6
`define CFG_HIGH_USED_MASK 8'h07
`define CFG_LOW_USED_MASK 8'h79

// interrupt bits, same layout in status, clear and enable
`define IRQ_COUNT_BIT 0
`define IRQ_TIMEOUT_BIT 1

// command bits
`define CMD_SLEEP_BIT 0
`define CMD_OFF_BIT 1

`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

// slow clock dividers per prescale code
`define DIV_CODE0 17'd1
`define DIV_CODE1 17'd4
`define DIV_CODE2 17'd8
`define DIV_CODE3 17'd16
`define DIV_CODE4 17'd128
`define DIV_CODE5 17'd1034
`define DIV_CODE6 17'd8192
`define DIV_CODE7 17'd65536

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* rtl/wake_timer_pkg.sv */
// types shared by the wake timer modules
package wake_timer_pkg;
	typedef enum logic [1:0] {
		ST_OFF,
		ST_SLEEP,
		ST_WAKE
	} power_state_t;
	typedef logic [2:0] prescale_t;
endpackage

/* rtl/slow_tick_gen.sv */
// synchronises the slow oscillators and divides the chosen one into tick pulses
`include "wake_timer_consts.svh"
module slow_tick_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rc_osc_clk,
	input wire logic crystal_osc_clk,
	input wire logic rc_osc_enable,
	input wire logic crystal_osc_enable,
	input wire logic slow_clock_select,
	input wire wake_timer_pkg::prescale_t tick_prescale_select,
	input wire logic restart,
	output logic tick
);
	import wake_timer_pkg::*;

	logic [1:0] rc_sync;
	logic [1:0] xo_sync;
	logic rc_last;
	logic xo_last;
	logic slow_edge;
	logic [16:0] edge_count;

	function automatic logic [16:0] divider(input prescale_t code);
		unique case (code)
			3'h0: divider = `DIV_CODE0;
			3'h1: divider = `DIV_CODE1;
			3'h2: divider = `DIV_CODE2;
			3'h3: divider = `DIV_CODE3;
			3'h4: divider = `DIV_CODE4;
			3'h5: divider = `DIV_CODE5;
			3'h6: divider = `DIV_CODE6;
			3'h7: divider = `DIV_CODE7;
		endcase
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_sync <= 2'h0;
			xo_sync <= 2'h0;
			rc_last <= 1'b0;
			xo_last <= 1'b0;
		end else begin
			rc_sync <= {rc_sync[0], rc_osc_clk};
			xo_sync <= {xo_sync[0], crystal_osc_clk};
			rc_last <= rc_sync[1];
			xo_last <= xo_sync[1];
		end
	end

	// rising edge of the selected, enabled oscillator
	assign slow_edge = slow_clock_select ? (rc_osc_enable & rc_sync[1] & ~rc_last)
		: (crystal_osc_enable & xo_sync[1] & ~xo_last);

	// prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			edge_count <= 17'd0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (slow_edge) begin
				if (edge_count + 17'd1 >= divider(tick_prescale_select)) begin
					edge_count <= 17'd0;
					tick <= 1'b1;
				end else begin
					edge_count <= edge_count + 17'd1;
				end
			end
		end
	end
endmodule

/* rtl/wake_down_counter.sv */
// 16-bit down counter that raises a timeout pulse and reloads itself
module wake_down_counter #(
	parameter int WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	input wire logic tick,
	output logic timeout
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] reload;
	logic running;

	// counts the load value in ticks, then one timeout
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			reload <= '0;
			running <= 1'b0;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (load) begin
				count <= load_value;
				reload <= load_value;
				running <= 1'b1;
			end else if (running && tick) begin
				if (count <= WIDTH'(1)) begin
					timeout <= 1'b1;
					count <= reload;
				end else begin
					count <= count - WIDTH'(1);
				end
			end
		end
	end

	property p_load_value;
		@(posedge aclk) disable iff (!aresetn)
		load |=> (count == $past(load_value)) && running;
	endproperty
	a_load_value: assert property (p_load_value) else $error("counter did not load value");

	property p_timeout_on_zero;
		@(posedge aclk) disable iff (!aresetn)
		(running && tick && !load && count > WIDTH'(1)) |=> !timeout;
	endproperty
	a_timeout_on_zero: assert property (p_timeout_on_zero) else $error("early timeout");
endmodule

/* testbench/slow_osc_model.sv */
// slow oscillator pair standing in for the rc and crystal sources
module slow_osc_model #(
	parameter int RC_HALF = 4,
	parameter int XTAL_HALF = 5
) (
	input wire logic aclk,
	input wire logic rc_osc_enable,
	input wire logic crystal_osc_enable,
	output logic rc_osc_clk,
	output logic crystal_osc_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	int rc_cnt = 0;
	int xtal_cnt = 0;
	initial begin
		rc_osc_clk = 1'b0;
		crystal_osc_clk = 1'b0;
	end
	// a disabled oscillator stands still, low
	always @(negedge aclk) begin
		if (!rc_osc_enable) begin
			rc_cnt <= 0;
			rc_osc_clk <= 1'b0;
		end else if (rc_cnt == RC_HALF - 1) begin
			rc_cnt <= 0;
			rc_osc_clk <= ~rc_osc_clk;
		end else begin
			rc_cnt <= rc_cnt + 1;
		end
	end
	always @(negedge aclk) begin
		if (!crystal_osc_enable) begin
			xtal_cnt <= 0;
			crystal_osc_clk <= 1'b0;
		end else if (xtal_cnt == XTAL_HALF - 1) begin
			xtal_cnt <= 0;
			crystal_osc_clk <= ~crystal_osc_clk;
		end else begin
			xtal_cnt <= xtal_cnt + 1;
		end
	end
endmodule

/* testbench/tb.sv */
// register-level testbench of the wake timer controller
`include "wake_timer_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic [13:0] awaddr = 14'h0000;
	logic wvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic [13:0] araddr = 14'h0000;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic rc_osc_clk, crystal_osc_clk, rc_osc_enable, crystal_osc_enable;
	logic retention_power_enable, sleep_state, idle_off_state, host_interrupt_pin;
	int mismatches = 0;
	int compares = 0;
	int cycle = 0;
	int t0, per, exp_cyc;
	int divs[6] = '{1, 4, 8, 16, 128, 1034};

	always #50 aclk = ~aclk;
	always @(posedge aclk) cycle <= cycle + 1;

	wake_timer_controller wake_timer_controller_i (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.rc_osc_clk(rc_osc_clk), .crystal_osc_clk(crystal_osc_clk),
		.rc_osc_enable(rc_osc_enable), .crystal_osc_enable(crystal_osc_enable),
		.retention_power_enable(retention_power_enable), .sleep_state(sleep_state),
		.idle_off_state(idle_off_state), .host_interrupt_pin(host_interrupt_pin));

	slow_osc_model slow_osc_model_i (.aclk(aclk), .rc_osc_enable(rc_osc_enable),
		.crystal_osc_enable(crystal_osc_enable), .rc_osc_clk(rc_osc_clk),
		.crystal_osc_clk(crystal_osc_clk));

	task automatic give_verdict();
		if (mismatches == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask

	task automatic chk_span(input string nm, input int lo, input int hi, input int g);
		compares++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("unexpected %s: expected %0d to %0d, seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("write response", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er,
			input string nm);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("read response", {30'h0, er}, {30'h0, rresp});
		if (er == `RESP_OKAY) begin
			chk(nm, {24'h000000, ed}, rdata);
		end
	endtask

	task automatic wait_wake();
		while (sleep_state !== 1'b0 && cycle - t0 < 20000) @(posedge aclk);
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("off state", 32'h1, idle_off_state);
		chk("sleep state", 32'h0, sleep_state);
		chk("retention", 32'h1, retention_power_enable);
		chk("irq pin", 32'h0, host_interrupt_pin);
		rd(`IDX_COUNT_A, 8'h00, `RESP_OKAY, "count a");
		rd(`IDX_THRESH_B, 8'h00, `RESP_OKAY, "threshold b");
		rd(12'h200, 8'h00, `RESP_SLVERR, "unmapped");
		wr(12'h200, 8'h01, `RESP_SLVERR);
		wr(`IDX_COUNT_A, 8'h05, `RESP_OKAY);
		rd(`IDX_COUNT_A, 8'h05, `RESP_OKAY, "count a");
		wr(`IDX_COUNT_A, 8'h00, `RESP_OKAY);
		wr(`IDX_IRQ_CLEAR, 8'h03, `RESP_OKAY);
		wr(`IDX_IRQ_ENABLE, 8'h03, `RESP_OKAY);
		rd(`IDX_IRQ_ENABLE, 8'h03, `RESP_OKAY, "irq enable");
		for (int c = 0; c < 6; c++) begin
			wr(`IDX_CONFIG_HIGH, 8'(c), `RESP_OKAY);
			wr(`IDX_CONFIG_LOW, (c == 0) ? 8'h29 : 8'h59, `RESP_OKAY);
			chk("rc enable", (c == 0) ? 32'h0 : 32'h1, rc_osc_enable);
			chk("crystal enable", (c == 0) ? 32'h1 : 32'h0, crystal_osc_enable);
			rd(`IDX_CONFIG_LOW, 8'h00, `RESP_OKAY, "config low");
			wr(`IDX_VALUE_HIGH, (c == 0) ? 8'h01 : 8'h00, `RESP_OKAY);
			wr(`IDX_VALUE_LOW, 8'h02, `RESP_OKAY);
			t0 = cycle;
			rd(`IDX_VALUE_HIGH, 8'h00, `RESP_OKAY, "value high");
			wr(`IDX_COMMAND, 8'h01, `RESP_OKAY);
			chk("retention", 32'h1, retention_power_enable);
			per = (c == 0) ? 10 : 8;
			exp_cyc = ((c == 0) ? 258 : 2) * divs[c] * per;
			wait_wake();
			chk_span("wake delay", exp_cyc - per - 4, exp_cyc + per + 8, cycle - t0);
			repeat (2) @(posedge aclk);
			chk("off state", 32'h1, idle_off_state);
			chk("irq pin", 32'h1, host_interrupt_pin);
			rd(`IDX_IRQ_STATUS, 8'h03, `RESP_OKAY, "status");
			rd(`IDX_COUNT_A, 8'h00, `RESP_OKAY, "count a");
			wr(`IDX_IRQ_CLEAR, 8'h03, `RESP_OKAY);
			chk("irq pin", 32'h0, host_interrupt_pin);
		end
		wr(`IDX_CONFIG_HIGH, 8'h00, `RESP_OKAY);
		wr(`IDX_THRESH_A, 8'h02, `RESP_OKAY);
		wr(`IDX_CONFIG_LOW, 8'h20, `RESP_OKAY);
		chk("rc enable", 32'h1, rc_osc_enable);
		chk("crystal enable", 32'h0, crystal_osc_enable);
		rd(`IDX_THRESH_A, 8'h02, `RESP_OKAY, "threshold a");
		wr(`IDX_IRQ_ENABLE, 8'h02, `RESP_OKAY);
		wr(`IDX_CONFIG_HIGH, 8'h00, `RESP_OKAY);
		wr(`IDX_CONFIG_LOW, 8'h59, `RESP_OKAY);
		wr(`IDX_VALUE_HIGH, 8'h00, `RESP_OKAY);
		wr(`IDX_VALUE_LOW, 8'h04, `RESP_OKAY);
		wr(`IDX_COMMAND, 8'h01, `RESP_OKAY);
		for (int k = 1; k <= 3; k++) begin
			t0 = cycle;
			wait_wake();
			repeat (2) @(posedge aclk);
			if (k < 3) begin
				chk("sleep state", 32'h1, sleep_state);
				rd(`IDX_COUNT_A, 8'(k), `RESP_OKAY, "count a");
			end
		end
		chk("off state", 32'h1, idle_off_state);
		rd(`IDX_COUNT_A, 8'h00, `RESP_OKAY, "count a");
		rd(`IDX_COUNT_B, 8'h00, `RESP_OKAY, "count b");
		chk("irq pin", 32'h1, host_interrupt_pin);
		wr(`IDX_IRQ_CLEAR, 8'h02, `RESP_OKAY);
		chk("irq pin", 32'h0, host_interrupt_pin);
		wr(`IDX_IRQ_ENABLE, 8'h03, `RESP_OKAY);
		chk("irq pin", 32'h1, host_interrupt_pin);
		wr(`IDX_IRQ_CLEAR, 8'h03, `RESP_OKAY);
		wr(`IDX_CONFIG_HIGH, 8'h00, `RESP_OKAY);
		wr(`IDX_CONFIG_LOW, 8'h50, `RESP_OKAY);
		wr(`IDX_VALUE_HIGH, 8'h00, `RESP_OKAY);
		wr(`IDX_VALUE_LOW, 8'h02, `RESP_OKAY);
		wr(`IDX_COMMAND, 8'h01, `RESP_OKAY);
		chk("retention", 32'h0, retention_power_enable);
		repeat (200) @(posedge aclk);
		chk("sleep state", 32'h1, sleep_state);
		rd(`IDX_STATE, 8'h01, `RESP_OKAY, "state");
		rd(`IDX_IRQ_STATUS, 8'h00, `RESP_OKAY, "status");
		wr(`IDX_COMMAND, 8'h02, `RESP_OKAY);
		chk("off state", 32'h1, idle_off_state);
		chk("retention", 32'h1, retention_power_enable);
		rd(`IDX_STATE, 8'h00, `RESP_OKAY, "state");
		give_verdict();
	end

	initial begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end
endmodule
